// ==== verilog/quadrature_position_init_control.sv ====
// The placing of the registers and register access over APB were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "qpic_defines.svh"
module quadrature_position_init_control (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // APB slave
  input wire qpic_pkg::apb_req_type i_apb,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  // Encoder pins and device idle state
  input wire qpic_pkg::encoder_pins_type i_pins,
  input wire logic i_idle,
  // Position and status
  output logic [31:0] o_position,
  output logic o_counting,
  output logic o_timer_mode
);
  import qpic_pkg::*;

  // Software registers
  logic [15:0] control;
  logic [15:0] config_bits;
  logic [31:0] ge_compare;
  logic [31:0] init_value;
  logic [31:0] position;
  // Pin synchroniser stages
  encoder_pins_type sync_first;
  encoder_pins_type sync_second;
  // Previous conditioned levels for edge detection
  logic prev_a;
  logic prev_b;
  logic prev_index;
  logic prev_home;
  // Sequence state for the index and home based load modes
  init_state_type init_state;
  init_state_type next_init_state;

  // Decoded fields
  logic [2:0] mode;
  logic [1:0] ccm;
  logic timer_mode;
  logic active;
  logic cur_a;
  logic cur_b;
  logic index_rise;
  logic home_rise;
  logic phase_match;
  logic index_event;
  logic step_up;
  logic step_down;
  // Bus decode
  logic setup_phase;
  logic access_phase;
  logic wr_en;
  logic mapped;
  logic [31:0] read_word;

  assign mode = control[`BIT_MODE_HI:`BIT_MODE_LO];
  assign ccm = config_bits[`BIT_CCM_HI:`BIT_CCM_LO];

  assign timer_mode = ccm[1];

  assign active = control[`BIT_COUNTER_ENABLE] &
                  ~(i_idle & control[`BIT_STOP_IN_IDLE]);

  // Two stage synchroniser, first stage feeds only the second
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      sync_first <= '0;
      sync_second <= '0;
    end else begin
      sync_first <= i_pins;
      sync_second <= sync_first;
    end
  end

  // Swap then invert before decode and match
  always_comb begin
    cur_a = config_bits[`BIT_SWAP] ? sync_second.phase_b : sync_second.phase_a;
    cur_b = config_bits[`BIT_SWAP] ? sync_second.phase_a : sync_second.phase_b;
    cur_a = cur_a ^ config_bits[`BIT_INV_A];
    cur_b = cur_b ^ config_bits[`BIT_INV_B];
  end

  // Edge history, taken from synchronised levels only
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      prev_a <= 1'b0;
      prev_b <= 1'b0;
      prev_index <= 1'b0;
      prev_home <= 1'b0;
    end else begin
      prev_a <= cur_a;
      prev_b <= cur_b;
      prev_index <= sync_second.index;
      prev_home <= sync_second.home;
    end
  end

  assign index_rise = sync_second.index & ~prev_index;
  assign home_rise = sync_second.home & ~prev_home;

  // Phase levels needed for an index match
  assign phase_match = (cur_b == control[`BIT_MATCH_B]) &
                       (cur_a == control[`BIT_MATCH_A]);

  // Index qualified by phase match in quadrature mode
  assign index_event = index_rise & ((ccm != `CCM_QUAD) | phase_match);

  // Quadrature x4 decode; a double change is a lost step and is dropped,
  // which is why the clock must run at least twice the count rate
  always_comb begin
    step_up = 1'b0;
    step_down = 1'b0;
    if ((cur_a ^ prev_a) ^ (cur_b ^ prev_b)) begin
      step_up = cur_a ^ prev_b;
      step_down = ~(cur_a ^ prev_b);
    end
  end

  // Home and index sequence, restarted by any control write
  always_comb begin
    next_init_state = init_state;
    case (init_state)
      // Waiting for home, or for index in next-index mode
      st_armed: begin
        if (mode == `MODE_LOAD_NEXT && index_event) begin
          next_init_state = st_done;
        end else if (home_rise) begin
          next_init_state = st_homed;
        end
      end
      // Home seen, counting index events
      st_homed: begin
        if (index_event) begin
          next_init_state = (mode == `MODE_LOAD_SECOND) ? st_one_index : st_done;
        end
      end
      // One index seen after home
      st_one_index: begin
        if (index_event) begin
          next_init_state = st_done;
        end
      end
      // Load made; wait for rearm
      st_done: begin
        next_init_state = st_done;
      end
      default: begin
        next_init_state = st_armed;
      end
    endcase
  end

  // Sequence register; halted counters freeze the sequence too
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      init_state <= st_armed;
    end else if (wr_en && i_apb.paddr == `OFS_CONTROL) begin
      init_state <= st_armed;
    end else if (active && !timer_mode) begin
      init_state <= next_init_state;
    end
  end

  // Position counter; index actions beat compare actions beat steps
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      position <= `WORD_RESET;
    end else if (wr_en && i_apb.paddr == `OFS_POSITION) begin
      position <= i_apb.pwdata;
    end else if (active && timer_mode) begin
      // Timer counts clocks, init mode ignored
      position <= position + 32'h0000_0001;
    end else if (active) begin
      case (mode)
        `MODE_RESET_EVERY: begin
          if (index_event) begin
            position <= `WORD_RESET;
          end else if (step_up) begin
            position <= position + 32'h0000_0001;
          end else if (step_down) begin
            position <= position - 32'h0000_0001;
          end
        end
        // Load from init value when sequence completes
        `MODE_LOAD_NEXT, `MODE_LOAD_FIRST, `MODE_LOAD_SECOND: begin
          if (init_state != st_done && next_init_state == st_done) begin
            position <= init_value;
          end else if (step_up) begin
            position <= position + 32'h0000_0001;
          end else if (step_down) begin
            position <= position - 32'h0000_0001;
          end
        end
        `MODE_RESET_GE: begin
          if (position == ge_compare) begin
            position <= `WORD_RESET;
          end else if (step_up) begin
            position <= position + 32'h0000_0001;
          end else if (step_down) begin
            position <= position - 32'h0000_0001;
          end
        end
        // Modulo between init value and compare value
        `MODE_MODULO: begin
          if (step_up) begin
            position <= (position == ge_compare) ? init_value : position + 32'h0000_0001;
          end else if (step_down) begin
            position <= (position == init_value) ? ge_compare : position - 32'h0000_0001;
          end
        end
        // Index leaves counter alone except the quadrature reset below for mode none; reserved code only steps
        default: begin
          if (step_up) begin
            position <= position + 32'h0000_0001;
          end else if (step_down) begin
            position <= position - 32'h0000_0001;
          end
        end
      endcase
      // Phase matched index resets both halves in quadrature mode, for init mode none only
      if (ccm == `CCM_QUAD && index_event && mode == `MODE_NONE) begin
        position <= `WORD_RESET;
      end
    end
  end

  // APB phases; zero wait states
  assign setup_phase = i_apb.psel & ~i_apb.penable;
  assign access_phase = i_apb.psel & i_apb.penable;
  assign wr_en = access_phase & i_apb.pwrite & mapped;
  assign o_pready = 1'b1;

  // Address decode and read mux
  always_comb begin
    mapped = 1'b1;
    read_word = `WORD_RESET;
    case (i_apb.paddr)
      `OFS_CONTROL: read_word = {16'h0000, control};
      `OFS_CONFIG: read_word = {16'h0000, config_bits};
      `OFS_GE_COMPARE: read_word = ge_compare;
      `OFS_INIT_VALUE: read_word = init_value;
      `OFS_POSITION: read_word = position;
      default: mapped = 1'b0;
    endcase
  end

  // Error only on unmapped access, during the access phase
  assign o_pslverr = access_phase & ~mapped;

  // Configuration registers; write masks keep reserved bits at zero
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      control <= `CONTROL_RESET;
      config_bits <= `CONFIG_RESET;
      ge_compare <= `WORD_RESET;
      init_value <= `WORD_RESET;
    end else if (wr_en) begin
      case (i_apb.paddr)
        `OFS_CONTROL: control <= i_apb.pwdata[15:0] & `CONTROL_WMASK;
        `OFS_CONFIG: config_bits <= i_apb.pwdata[15:0] & `CONFIG_WMASK;
        `OFS_GE_COMPARE: ge_compare <= i_apb.pwdata;
        `OFS_INIT_VALUE: init_value <= i_apb.pwdata;
        default: ;
      endcase
    end
  end

  // Read data captured in setup so it stands through the access phase
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_prdata <= `WORD_RESET;
    end else if (setup_phase) begin
      o_prdata <= read_word;
    end
  end

  // Status outputs from flops
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_position <= `WORD_RESET;
      o_counting <= 1'b0;
      o_timer_mode <= 1'b0;
    end else begin
      o_position <= position;
      o_counting <= active;
      o_timer_mode <= timer_mode;
    end
  end
endmodule : quadrature_position_init_control
`default_nettype wire

// ==== verilog/qpic_defines.svh ====
`ifndef QPIC_DEFINES_SVH
`define QPIC_DEFINES_SVH
// Register byte offsets
`define OFS_CONTROL 8'h00
`define OFS_CONFIG 8'h04
`define OFS_GE_COMPARE 8'h08
`define OFS_INIT_VALUE 8'h0C
`define OFS_POSITION 8'h10
// Control field positions
`define BIT_COUNTER_ENABLE 15
`define BIT_STOP_IN_IDLE 13
`define BIT_MODE_HI 12
`define BIT_MODE_LO 10
`define BIT_MATCH_B 9
`define BIT_MATCH_A 8
`define CONTROL_WMASK 16'hBF00
// Config field positions
`define BIT_SWAP 0
`define BIT_INV_A 1
`define BIT_INV_B 2
`define BIT_CCM_LO 3
`define BIT_CCM_HI 4
`define CONFIG_WMASK 16'h001F
// Reset values
`define CONTROL_RESET 16'h0000
`define CONFIG_RESET 16'h0000
`define WORD_RESET 32'h0000_0000
// Init mode codes
`define MODE_NONE 3'h0
`define MODE_RESET_EVERY 3'h1
`define MODE_LOAD_NEXT 3'h2
`define MODE_LOAD_FIRST 3'h3
`define MODE_LOAD_SECOND 3'h4
`define MODE_RESET_GE 3'h5
`define MODE_MODULO 3'h6
// Counter control mode codes
`define CCM_QUAD 2'h0
`endif

// ==== verilog/qpic_pkg.sv ====
package qpic_pkg;
  // Encoder pins as one bundle
  typedef struct packed {
    logic phase_a;
    logic phase_b;
    logic index;
    logic home;
  } encoder_pins_type;
  // APB request from the master
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
  } apb_req_type;
  // Home and index sequence for the load modes
  typedef enum logic [1:0] {
    st_armed,
    st_homed,
    st_one_index,
    st_done
  } init_state_type;
endpackage : qpic_pkg

// ==== tb/qpic_assertions.sv ====
`timescale 1ns/1ps
`default_nettype none
// Port-level checker for the encoder init control block
module qpic_assertions (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // Bus and status ports
  input wire qpic_pkg::apb_req_type i_apb,
  input wire logic [31:0] o_prdata,
  input wire logic o_pready,
  input wire logic o_pslverr,
  input wire logic [31:0] o_position,
  input wire logic o_counting,
  input wire logic o_timer_mode
);
  import qpic_pkg::*;
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_rst);
  // Access phase, read and write decode
  logic acc;
  logic rd;
  logic wr;
  logic mapped;
  assign acc = i_apb.psel && i_apb.penable;
  assign rd = acc && !i_apb.pwrite;
  assign wr = acc && i_apb.pwrite;
  // Five aligned words from 0x00 to 0x10
  assign mapped = (i_apb.paddr[1:0] == 2'h0) && (i_apb.paddr <= 8'h10);
  ready_high_a: assert property (o_pready) else $error("pready low");
  err_decode_a: assert property (o_pslverr == (acc && !mapped)) else $error("bad pslverr");
  prdata_hold_a: assert property (!(i_apb.psel && !i_apb.penable) |=> $stable(o_prdata))
    else $error("prdata moved");
  unmap_zero_a: assert property (rd && !mapped |-> o_prdata == 32'h0)
    else $error("unmapped read data");
  ctrl_zero_a: assert property (
    rd && i_apb.paddr == 8'h00 |-> (o_prdata & ~32'h0000_BF00) == 32'h0)
    else $error("control spare bits set");
  cfg_zero_a: assert property (rd && i_apb.paddr == 8'h04 |-> (o_prdata & ~32'h0000_001F) == 32'h0)
    else $error("config spare bits set");
  // Halted counters hold unless software writes the position
  halt_hold_a: assert property (
    !o_counting && !$past(o_counting) && !$past(o_counting, 2) && !$past(wr) && !$past(wr, 2)
    |-> $stable(o_position)) else $error("position moved while halted");
  timer_step_a: assert property (
    o_timer_mode && o_counting && $past(o_timer_mode, 2) && $past(o_counting, 2)
    && !$past(wr) && !$past(wr, 2) |-> o_position == $past(o_position) + 32'h1)
    else $error("timer did not step by one");
endmodule : qpic_assertions
bind quadrature_position_init_control qpic_assertions i_chk (.i_clk(i_clk), .i_rst(i_rst),
  .i_apb(i_apb), .o_prdata(o_prdata), .o_pready(o_pready), .o_pslverr(o_pslverr),
  .o_position(o_position), .o_counting(o_counting), .o_timer_mode(o_timer_mode));
`default_nettype wire

// ==== tb/qpic_encoder_model.sv ====
`timescale 1ns/1ps
`default_nettype none
// Incremental encoder with index and home outputs
module qpic_encoder_model (
  // Clock used only to pace pin changes
  input wire logic i_clk,
  // Encoder pins
  output var qpic_pkg::encoder_pins_type o_pins
);
  import qpic_pkg::*;
  // Gray state 0..3; rising count has A leading B
  logic [1:0] q = 2'h0;
  initial o_pins = '0;
  task automatic step(input logic up);
    q = up ? q + 2'h1 : q - 2'h1;
    @(posedge i_clk);
    o_pins.phase_a <= q[1] ^ q[0];
    o_pins.phase_b <= q[1];
    repeat (3) @(posedge i_clk);
  endtask : step
  // Home (sel high) or index pulse, wide enough for the synchroniser
  task automatic pulse(input logic sel);
    @(posedge i_clk);
    o_pins.home <= sel;
    o_pins.index <= !sel;
    repeat (4) @(posedge i_clk);
    o_pins.home <= 1'b0;
    o_pins.index <= 1'b0;
    repeat (3) @(posedge i_clk);
  endtask : pulse
endmodule : qpic_encoder_model
`default_nettype wire

// ==== tb/testbench.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "qpic_defines.svh"
module testbench;
  import qpic_pkg::*;
  // Stimulus and observed ports
  logic i_clk = 1'b0;
  logic i_rst = 1'b1;
  logic i_idle = 1'b0;
  apb_req_type apb = '0;
  encoder_pins_type pins;
  logic [31:0] o_prdata, o_position, r, r2;
  logic o_pready, o_pslverr, o_counting, o_timer_mode, e;
  int mismatches = 0;
  int n_tests = 0;
  always #2 i_clk = ~i_clk;
  quadrature_position_init_control i_dut (.i_clk(i_clk), .i_rst(i_rst), .i_apb(apb),
    .o_prdata(o_prdata), .o_pready(o_pready), .o_pslverr(o_pslverr), .i_pins(pins),
    .i_idle(i_idle), .o_position(o_position), .o_counting(o_counting),
    .o_timer_mode(o_timer_mode));
  qpic_encoder_model i_enc (.i_clk(i_clk), .o_pins(pins));
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      mismatches++;
      $display("CHECK FAILED at %0t: got %h want %h", $time, seen, exp);
    end
  endtask : check
  // One bus transfer; held until pready is seen
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic err);
    @(posedge i_clk);
    apb <= '{1'b1, 1'b0, w, a, d};
    @(posedge i_clk);
    apb.penable <= 1'b1;
    do @(posedge i_clk); while (o_pready !== 1'b1);
    q = o_prdata;
    err = o_pslverr;
    apb <= '0;
  endtask : xfer
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'b1, a, d, r, e);
  endtask : wr
  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    xfer(1'b0, a, 32'h0, r, e);
    check(r, exp);
  endtask : rdchk
  // Preset position 0x40, arm a mode, fire home and index pulses
  task automatic run_case(input logic [31:0] cfg, input logic [31:0] ctl, input int nh,
                          input int ni, input logic [1:0] qq, input logic [31:0] exp);
    while (i_enc.q != qq) i_enc.step(1'b1);
    wr(`OFS_CONFIG, cfg);
    wr(`OFS_POSITION, 32'h0000_0040);
    wr(`OFS_CONTROL, ctl);
    repeat (nh) i_enc.pulse(1'b1);
    repeat (ni) i_enc.pulse(1'b0);
    repeat (4) @(posedge i_clk);
    rdchk(`OFS_POSITION, exp);
  endtask : run_case
  task automatic summarize;
    $display("checks %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : summarize
  // Watchdog well beyond the expected run
  initial begin
    #100000;
    mismatches++;
    summarize();
  end
  initial begin
    repeat (6) @(posedge i_clk);
    i_rst <= 1'b0;
    for (int k = 0; k < 5; k++) rdchk(8'(4 * k), 32'h0000_0000);
    wr(`OFS_CONTROL, 32'hFFFF_FFFF);
    rdchk(`OFS_CONTROL, 32'h0000_BF00);
    wr(`OFS_CONFIG, 32'hFFFF_FFFF);
    rdchk(`OFS_CONFIG, 32'h0000_001F);
    xfer(1'b0, 8'h14, 32'h0, r, e);
    check({31'h0, e}, 32'h1);
    // Unaligned high address: refused, must not alias onto a register
    xfer(1'b1, 8'hE3, 32'h0000_0000, r, e);
    check({31'h0, e}, 32'h1);
    rdchk(`OFS_CONTROL, 32'h0000_BF00);
    xfer(1'b0, 8'hE3, 32'h0000_0000, r, e);
    check(r, 32'h0000_0000);
    check({31'h0, e}, 32'h1);
    $display("register test done");
    wr(`OFS_INIT_VALUE, 32'h0000_0100);
    run_case(32'h0, 32'h0000_8400, 0, 1, 2'h0, 32'h0000_0000);
    run_case(32'h0, 32'h0000_8600, 0, 1, 2'h0, 32'h0000_0040);
    run_case(32'h0, 32'h0000_8500, 0, 1, 2'h1, 32'h0000_0000);
    run_case(32'h0, 32'h0000_8800, 0, 1, 2'h0, 32'h0000_0100);
    run_case(32'h0, 32'h0000_8C00, 1, 1, 2'h0, 32'h0000_0100);
    run_case(32'h0, 32'h0000_8C00, 0, 1, 2'h0, 32'h0000_0040);
    run_case(32'h0, 32'h0000_9000, 1, 1, 2'h0, 32'h0000_0040);
    run_case(32'h0, 32'h0000_9000, 1, 2, 2'h0, 32'h0000_0100);
    run_case(32'h0, 32'h0000_8000, 0, 1, 2'h0, 32'h0000_0000);
    run_case(32'h0, 32'h0000_8300, 0, 1, 2'h0, 32'h0000_0040);
    run_case(32'h0, 32'h0000_9F00, 0, 1, 2'h0, 32'h0000_0040);
    run_case(32'h1, 32'h0000_8600, 0, 1, 2'h1, 32'h0000_0000);
    run_case(32'h2, 32'h0000_8500, 0, 1, 2'h0, 32'h0000_0000);
    // Outside quadrature mode the phase match does not gate the index
    run_case(32'h8, 32'h0000_8600, 0, 1, 2'h0, 32'h0000_0000);
    $display("index mode test done");
    wr(`OFS_CONFIG, 32'h0);
    wr(`OFS_GE_COMPARE, 32'h0000_0044);
    wr(`OFS_POSITION, 32'h0000_0040);
    wr(`OFS_CONTROL, 32'h0000_9400);
    repeat (4) i_enc.step(1'b1);
    rdchk(`OFS_POSITION, 32'h0000_0000);
    wr(`OFS_INIT_VALUE, 32'h0000_0010);
    wr(`OFS_GE_COMPARE, 32'h0000_0012);
    wr(`OFS_POSITION, 32'h0000_0011);
    wr(`OFS_CONTROL, 32'h0000_9800);
    repeat (2) i_enc.step(1'b1);
    rdchk(`OFS_POSITION, 32'h0000_0010);
    i_enc.step(1'b0);
    rdchk(`OFS_POSITION, 32'h0000_0012);
    $display("compare test done");
    wr(`OFS_CONTROL, 32'h0);
    wr(`OFS_POSITION, 32'h0000_0055);
    repeat (4) i_enc.step(1'b1);
    check({31'h0, o_counting}, 32'h0);
    rdchk(`OFS_POSITION, 32'h0000_0055);
    wr(`OFS_CONTROL, 32'h0000_A000);
    i_idle <= 1'b1;
    repeat (2) i_enc.step(1'b1);
    check({31'h0, o_counting}, 32'h0);
    rdchk(`OFS_POSITION, 32'h0000_0055);
    i_idle <= 1'b0;
    repeat (3) @(posedge i_clk);
    repeat (2) i_enc.step(1'b1);
    rdchk(`OFS_POSITION, 32'h0000_0057);
    wr(`OFS_CONTROL, 32'h0000_8000);
    i_idle <= 1'b1;
    repeat (3) @(posedge i_clk);
    check({31'h0, o_counting}, 32'h1);
    i_idle <= 1'b0;
    $display("enable and idle test done");
    wr(`OFS_CONFIG, 32'h0000_0010);
    wr(`OFS_CONTROL, 32'h0000_8400);
    i_enc.pulse(1'b0);
    check({31'h0, o_timer_mode}, 32'h1);
    xfer(1'b0, `OFS_POSITION, 32'h0, r2, e);
    xfer(1'b0, `OFS_POSITION, 32'h0, r, e);
    check(r - r2, 32'h0000_0003);
    wr(`OFS_CONFIG, 32'h0000_0018);
    repeat (2) @(posedge i_clk);
    check({31'h0, o_timer_mode}, 32'h1);
    wr(`OFS_CONFIG, 32'h0);
    repeat (2) @(posedge i_clk);
    check({31'h0, o_timer_mode}, 32'h0);
    $display("timer test done");
    // Reset in mid-run while enabled with a nonzero position
    i_rst <= 1'b1;
    repeat (2) @(posedge i_clk);
    i_rst <= 1'b0;
    rdchk(`OFS_CONTROL, 32'h0000_0000);
    rdchk(`OFS_CONFIG, 32'h0000_0000);
    rdchk(`OFS_POSITION, 32'h0000_0000);
    check({31'h0, o_counting}, 32'h0);
    check({31'h0, o_timer_mode}, 32'h0);
    $display("reset test done");
    summarize();
  end
endmodule : testbench
`default_nettype wire
